// *** logic/dsr_pkg.sv ***
`default_nettype none
package dsr_pkg;
    // serial frame geometry
    localparam int       RES_BITS      = 12;
    localparam int       CNT_W         = 6;
    localparam int       FIFO_DEPTH    = 8;
    localparam int       FIFO_WIDTH    = 64;
    localparam logic [5:0] PD_EDGE_MIN   = 6'h02;
    localparam logic [5:0] PD_EDGE_MAX   = 6'h0A;
    localparam logic [5:0] TRACK_EDGE    = 6'h0D;
    localparam logic [5:0] MSB_EDGE      = 6'h02;
    localparam logic [5:0] CONV_EDGES    = 6'h0E;
    localparam logic [5:0] WORD_EDGES    = 6'h10;
    localparam logic [5:0] DUAL_END_EDGE = 6'h20;
    localparam logic [5:0] DUMMY_EDGES   = 6'h10;
    // timing, in ns and in 100 MHz cycles
    localparam int CLK_NS        = 10;
    localparam int FULL_WAKE_NS  = 1500000;
    localparam int PART_WAKE_NS  = 1000;
    localparam int PART_DOWN_NS  = 67000;
    localparam int FULL_WAKE_CYC = (FULL_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PART_WAKE_CYC = (PART_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PART_DOWN_CYC = (PART_DOWN_NS + CLK_NS - 1) / CLK_NS;
    localparam int QUIET_CYC     = 4;
    localparam int SCLK_HALF_CYC = 8;
    localparam int TMR_W         = 18;
    // wake kinds asked of the host
    localparam logic [1:0] WAKE_NONE = 2'h0;
    localparam logic [1:0] WAKE_PART = 2'h1;
    localparam logic [1:0] WAKE_FULL = 2'h2;

    typedef enum logic [2:0] {
        PWR_NORMAL  = 3'h1,
        PWR_PARTIAL = 3'h2,
        PWR_FULL    = 3'h4
    } dsr_pwr_t;
endpackage
`default_nettype wire

// *** logic/dsr_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface dsr_link_if;
    logic selN;
    logic sclk;
    logic lineAOut;
    logic lineAOe;
    logic lineBOut;
    logic lineBOe;
    modport device (input selN, input sclk, output lineAOut,
                    output lineAOe, output lineBOut, output lineBOe);
    modport host   (output selN, output sclk, input lineAOut,
                    input lineBOut);
endinterface
`default_nettype wire

// *** logic/dsr_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsr_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doWr;
    logic             doRd;

    // honest full and empty from the fill count
    assign inReady  = count != (AW+1)'(DEPTH);
    assign outValid = count != '0;
    assign outData  = mem[rdPtr];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;

    // storage
    always_ff @(posedge clock) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end

    // pointers and count
    always_ff @(posedge clock) begin
        if (srst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule // dsr_fifo
`default_nettype wire

// *** logic/dsr_adc_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsr_adc_end
    import dsr_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                srst,
    dsr_link_if.device               link,
    input  wire logic [RES_BITS-1:0] convA,
    input  wire logic [RES_BITS-1:0] convB,
    output var  dsr_pwr_t            powerState,
    output logic                     holdMode,
    output logic                     frameActive
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge finding
    logic [1:0]          selSync;
    logic [1:0]          sclkSync;
    logic                selPrev;
    logic                sclkPrev;
    logic                selFall;
    logic                selRise;
    logic                sclkFall;
    logic                sclkRise;
    logic [CNT_W-1:0]    fallCnt;
    logic [CNT_W-1:0]    nextCnt;
    logic [RES_BITS-1:0] sampleA;
    logic [RES_BITS-1:0] sampleB;
    logic                bitA;
    logic                bitB;

    // two flops on each pin before any use
    always_ff @(posedge clock) begin
        if (srst) begin
            selSync  <= 2'h3;
            sclkSync <= 2'h3;
            selPrev  <= 1'b1;
            sclkPrev <= 1'b1;
        end else begin
            selSync  <= {selSync[0], link.selN};
            sclkSync <= {sclkSync[0], link.sclk};
            selPrev  <= selSync[1];
            sclkPrev <= sclkSync[1];
        end
    end

    // edges seen on the synchronised pins
    assign selFall  = selPrev & ~selSync[1];
    assign selRise  = ~selPrev & selSync[1];
    assign sclkFall = sclkPrev & ~sclkSync[1];
    assign sclkRise = ~sclkPrev & sclkSync[1];
    assign nextCnt  = fallCnt + 6'h01;

    ////////////////////////////////////////////////////////////////////
    // bit presented after falling edge m of one word
    function automatic logic wordBit(
        input logic [RES_BITS-1:0] w,
        input logic [CNT_W-1:0]    m
    );
        logic [CNT_W-1:0] idx;
        idx = (MSB_EDGE + 6'h0B) - m;
        if (m >= MSB_EDGE && m <= TRACK_EDGE) begin
            wordBit = w[idx[3:0]];
        end else begin
            wordBit = 1'b0;
        end
    endfunction

    // first word on a line is its own result, second the other's
    always_comb begin
        if (nextCnt < WORD_EDGES) begin
            bitA = wordBit(sampleA, nextCnt);
            bitB = wordBit(sampleB, nextCnt);
        end else begin
            bitA = wordBit(sampleB, nextCnt - WORD_EDGES);
            bitB = wordBit(sampleA, nextCnt - WORD_EDGES);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame tracking and falling edge count
    always_ff @(posedge clock) begin
        if (srst) begin
            frameActive <= 1'b0;
            fallCnt     <= '0;
        end else if (selFall) begin
            // a coincident clock fall is dropped here
            frameActive <= 1'b1;
            fallCnt     <= '0;
        end else if (selRise) begin
            frameActive <= 1'b0;
        end else if (frameActive && sclkFall &&
                     fallCnt < DUAL_END_EDGE) begin
            fallCnt <= nextCnt;
        end
    end

    // sample both converters at select fall
    always_ff @(posedge clock) begin
        if (srst) begin
            sampleA <= '0;
            sampleB <= '0;
        end else if (selFall) begin
            sampleA <= convA;
            sampleB <= convB;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result lines
    always_ff @(posedge clock) begin
        if (srst) begin
            link.lineAOut <= 1'b0;
            link.lineBOut <= 1'b0;
            link.lineAOe  <= 1'b0;
            link.lineBOe  <= 1'b0;
        end else if (selFall) begin
            // first leading zero at select fall
            link.lineAOut <= 1'b0;
            link.lineBOut <= 1'b0;
            link.lineAOe  <= 1'b1;
            link.lineBOe  <= 1'b1;
        end else if (selRise) begin
            link.lineAOut <= 1'b0;
            link.lineBOut <= 1'b0;
            link.lineAOe  <= 1'b0;
            link.lineBOe  <= 1'b0;
        end else if (frameActive && sclkFall &&
                     fallCnt < DUAL_END_EDGE) begin
            if (nextCnt == DUAL_END_EDGE) begin
                link.lineAOut <= 1'b0;
                link.lineBOut <= 1'b0;
                link.lineAOe  <= 1'b0;
                link.lineBOe  <= 1'b0;
            end else begin
                // last result bit leaves on fall 13
                link.lineAOut <= bitA;
                link.lineBOut <= bitB;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // track and hold control
    always_ff @(posedge clock) begin
        if (srst) begin
            holdMode <= 1'b0;
        end else if (selFall) begin
            holdMode <= 1'b1;
        end else if (selRise) begin
            holdMode <= 1'b0;
        end else if (frameActive && sclkRise &&
                     fallCnt >= TRACK_EDGE) begin
            // early rises leave the count below, so do nothing
            holdMode <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power state from the count at select rise
    always_ff @(posedge clock) begin
        if (srst) begin
            powerState <= PWR_NORMAL;
        end else if (selRise && frameActive) begin
            if (fallCnt < PD_EDGE_MIN) begin
                powerState <= powerState;
            end else if (fallCnt < PD_EDGE_MAX) begin
                case (powerState)
                    PWR_NORMAL:  powerState <= PWR_PARTIAL;
                    PWR_PARTIAL: powerState <= PWR_FULL;
                    PWR_FULL:    powerState <= PWR_FULL;
                    default:     powerState <= PWR_PARTIAL;
                endcase
            end else begin
                // held past tenth fall: powered, data or dummy
                powerState <= PWR_NORMAL;
            end
        end
    end
endmodule // dsr_adc_end
`default_nettype wire

// *** logic/dsr_host_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsr_host_end
    import dsr_pkg::*;
#(
    parameter int FULL_WAKE = FULL_WAKE_CYC,
    parameter int PART_DOWN = PART_DOWN_CYC,
    parameter int HALF_CYC  = SCLK_HALF_CYC
) (
    input  wire logic              clock,
    input  wire logic              srst,
    dsr_link_if.host               link,
    input  wire logic              cmdValid,
    output logic                   cmdReady,
    input  wire logic [CNT_W-1:0]  cmdEdges,
    input  wire logic [1:0]        cmdWake,
    output logic                   rspValid,
    input  wire logic              rspReady,
    output logic [FIFO_WIDTH-1:0]  rspData
);
    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_SETUP = 5'h02,
        H_CLOCK = 5'h04,
        H_QUIET = 5'h08,
        H_WAIT  = 5'h10
    } dsr_hst_t;

    dsr_hst_t          state;
    logic [1:0]        aSync;
    logic [1:0]        bSync;
    logic [7:0]        divCnt;
    logic [CNT_W-1:0]  edgeCnt;
    logic [CNT_W-1:0]  target;
    logic [1:0]        wake;
    logic              boot;
    logic [31:0]       shA;
    logic [31:0]       shB;
    logic [TMR_W-1:0]  frameTmr;
    logic [TMR_W-1:0]  downTmr;
    logic [TMR_W-1:0]  need;
    logic              halfDone;
    logic              take;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic [FIFO_WIDTH-1:0] fifoOut;
    logic              pop;
    logic              push;

    ////////////////////////////////////////////////////////////////////
    // result pins come from another domain
    always_ff @(posedge clock) begin
        if (srst) begin
            aSync <= '0;
            bSync <= '0;
        end else begin
            aSync <= {aSync[0], link.lineAOut};
            bSync <= {bSync[0], link.lineBOut};
        end
    end

    assign halfDone = divCnt == 8'(HALF_CYC - 1);
    assign take     = state == H_IDLE && cmdValid && cmdReady;
    assign push     = state == H_QUIET && target >= CONV_EDGES;
    // wait from select fall before the next frame
    always_comb begin
        case (wake)
            WAKE_FULL: need = TMR_W'(FULL_WAKE);
            WAKE_PART: need = (downTmr < TMR_W'(PART_DOWN)) ?
                              TMR_W'(FULL_WAKE) :
                              TMR_W'(PART_WAKE_CYC);
            default:   need = TMR_W'(QUIET_CYC);
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // frame sequencer
    always_ff @(posedge clock) begin
        if (srst) begin
            state     <= H_IDLE;
            link.selN <= 1'b1;
            link.sclk <= 1'b1;
            divCnt    <= '0;
            edgeCnt   <= '0;
            target    <= '0;
            wake      <= WAKE_NONE;
            boot      <= 1'b1;
            cmdReady  <= 1'b0;
            shA       <= '0;
            shB       <= '0;
        end else begin
            divCnt <= halfDone ? 8'h00 : divCnt + 8'h01;
            case (state)
                H_IDLE: begin
                    divCnt <= '0;
                    if (boot) begin
                        // one dummy frame after power-on
                        boot      <= 1'b0;
                        target    <= DUMMY_EDGES;
                        wake      <= WAKE_PART;
                        link.selN <= 1'b0;
                        shA       <= '0;
                        shB       <= '0;
                        state     <= H_SETUP;
                        cmdReady  <= 1'b0;
                    end else if (take) begin
                        // command frames of any length
                        target    <= cmdEdges;
                        wake      <= cmdWake;
                        link.selN <= 1'b0;
                        shA       <= '0;
                        shB       <= '0;
                        state     <= H_SETUP;
                        cmdReady  <= 1'b0;
                    end else begin
                        cmdReady <= fifoInReady;
                    end
                end
                H_SETUP: begin
                    if (halfDone) begin
                        link.sclk <= 1'b0;
                        edgeCnt   <= 6'h01;
                        state     <= H_CLOCK;
                    end
                end
                H_CLOCK: begin
                    if (halfDone && !link.sclk) begin
                        // rising edge k carries fall k's bit
                        link.sclk <= 1'b1;
                        shA <= {shA[30:0], aSync[1]};
                        shB <= {shB[30:0], bSync[1]};
                        if (edgeCnt >= target) begin
                            link.selN <= 1'b1;
                            state     <= H_QUIET;
                        end
                    end else if (halfDone) begin
                        link.sclk <= 1'b0;
                        edgeCnt   <= edgeCnt + 6'h01;
                    end
                end
                H_QUIET: begin
                    state <= H_WAIT;
                end
                H_WAIT: begin
                    if (frameTmr >= need) begin
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // time since select fall, time spent powered down
    always_ff @(posedge clock) begin
        if (srst) begin
            frameTmr <= '0;
            downTmr  <= '0;
        end else begin
            if (state == H_IDLE && (boot || take)) begin
                frameTmr <= '0;
            end else if (frameTmr != '1) begin
                frameTmr <= frameTmr + 1'b1;
            end
            if (state == H_QUIET && target >= PD_EDGE_MIN &&
                target < PD_EDGE_MAX) begin
                downTmr <= '0;
            end else if (downTmr != '1) begin
                downTmr <= downTmr + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result buffer; a full one holds off new commands
    dsr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) resultFifo (
        .clock    (clock),
        .srst     (srst),
        .inValid  (push),
        .inReady  (fifoInReady),
        .inData   ({shA, shB}),
        .outValid (fifoOutValid),
        .outReady (pop),
        .outData  (fifoOut)
    );

    // registered answer stage
    assign pop = fifoOutValid && (!rspValid || rspReady);
    always_ff @(posedge clock) begin
        if (srst) begin
            rspValid <= 1'b0;
            rspData  <= '0;
        end else if (pop) begin
            rspValid <= 1'b1;
            rspData  <= fifoOut;
        end else if (rspReady) begin
            rspValid <= 1'b0;
        end
    end
endmodule // dsr_host_end
`default_nettype wire

// *** tb/dsr_link_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsr_link_asserts (
    input wire logic clock,
    input wire logic srst,
    input wire logic selN,
    input wire logic sclk,
    input wire logic lineAOut,
    input wire logic lineAOe,
    input wire logic lineBOut,
    input wire logic lineBOe
);
    logic       sclkQ;
    logic [5:0] falls;

    // previous serial clock level
    always_ff @(posedge clock) begin
        sclkQ <= sclk;
    end

    // serial clock falls seen while the frame is open
    always_ff @(posedge clock) begin
        if (srst || selN) begin
            falls <= 6'h00;
        end else if (sclkQ && !sclk) begin
            falls <= falls + 6'h01;
        end
    end

    ////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // result lines against frame select and clock count
    a_drive_on_fall: assert property (
        $fell(selN) |-> ##[1:6] lineAOe && lineBOe)
        else $error("lines not driven after select fall");
    a_float_on_rise: assert property (
        $rose(selN) |-> ##[1:6] !lineAOe && !lineBOe)
        else $error("lines still driven after select rise");
    a_float_idle: assert property (
        selN [*8] |-> !lineAOe && !lineBOe)
        else $error("lines driven outside a frame");
    a_lead_zero: assert property (
        $rose(sclk) && !selN && falls == 6'h01 |-> !lineAOut && !lineBOut)
        else $error("second leading zero missing");
    a_trail_zero: assert property (
        $rose(sclk) && !selN && falls inside {[6'h0E:6'h11]}
        |-> !lineAOut && !lineBOut)
        else $error("trailing zeros missing");
    a_drive_frame: assert property (
        $rose(sclk) && !selN && falls != 6'h00 && falls < 6'h20
        |-> lineAOe && lineBOe)
        else $error("lines released inside a frame");
    a_float_dual: assert property (
        !selN && falls == 6'h20 |-> ##[0:6] !lineAOe && !lineBOe)
        else $error("lines driven after fall 32");
    a_sclk_idle: assert property (
        selN |-> sclk)
        else $error("serial clock low outside a frame");
    a_sclk_low_half: assert property (
        $fell(sclk) |-> !sclk [*6])
        else $error("serial clock low phase too short");
endmodule // dsr_link_asserts
`default_nettype wire

// *** tb/dual_adc_serial_readout_power_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module dual_adc_serial_readout_power_tb
    import dsr_pkg::*;
;
    logic                  clock       = 1'b0;
    logic                  srst        = 1'b1;
    logic [RES_BITS-1:0]   convA       = 12'h000;
    logic [RES_BITS-1:0]   convB       = 12'h000;
    logic [RES_BITS-1:0]   saveA       = 12'h000;
    logic [RES_BITS-1:0]   saveB       = 12'hFFF;
    logic                  cmdValid    = 1'b0;
    logic                  rspReady    = 1'b0;
    logic [CNT_W-1:0]      cmdEdges    = 6'h00;
    logic [1:0]            cmdWake     = 2'h0;
    logic                  cmdReady;
    logic                  rspValid;
    logic [FIFO_WIDTH-1:0] rspData;
    logic                  holdMode;
    logic                  frameActive;
    dsr_pwr_t              powerState;
    logic [RES_BITS-1:0]   qa[$];
    logic [RES_BITS-1:0]   qb[$];
    int                    error_cnt   = 0;
    int                    checks_done = 0;

    // clock and the two ends joined by the link
    always #5 clock = ~clock;
    dsr_link_if link ();
    dsr_adc_end dsr_adc_end_i (.clock(clock), .srst(srst), .link(link),
        .convA(convA), .convB(convB), .powerState(powerState),
        .holdMode(holdMode), .frameActive(frameActive));
    dsr_host_end #(.FULL_WAKE(200), .PART_DOWN(50), .HALF_CYC(8))
        dsr_host_end_i (.clock(clock), .srst(srst), .link(link),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdEdges(cmdEdges),
        .cmdWake(cmdWake), .rspValid(rspValid), .rspReady(rspReady),
        .rspData(rspData));
    dsr_link_asserts dsr_link_asserts_i (.clock(clock), .srst(srst),
        .selN(link.selN), .sclk(link.sclk), .lineAOut(link.lineAOut),
        .lineAOe(link.lineAOe), .lineBOut(link.lineBOut),
        .lineBOe(link.lineBOe));

    ////////////////////////////////////////////////
    // verdict and end of run
    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for a level
    task automatic wait_lv(ref logic sig, input logic lv, input int lim,
                           output logic ok);
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(posedge clock);
            #1;
            ok = (sig === lv);
        end
    endtask

    // a wait that ran out ends the run
    task automatic need(input logic ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: wait ran out", $time);
            final_report();
        end
    endtask

    // 16 bit word taken on rises: zero, result, three zeros
    function automatic logic [15:0] w16(input logic [11:0] v);
        return {1'b0, v, 3'b000};
    endfunction

    // one host frame; converter inputs change once sampled
    task automatic frame(input logic [5:0] edges, input logic [1:0] wake,
                         input dsr_pwr_t pwr);
        logic ok;
        wait_lv(cmdReady, 1'b1, 30000, ok);
        need(ok);
        saveA = saveA + 12'h1D3;
        saveB = saveB - 12'h2B7;
        convA = saveA;
        convB = saveB;
        cmdEdges = edges;
        cmdWake = wake;
        cmdValid = 1'b1;
        @(posedge clock);
        #1;
        cmdValid = 1'b0;
        wait_lv(frameActive, 1'b1, 20, ok);
        need(ok);
        chk(holdMode, 1'b1);
        convA = ~saveA;
        convB = ~saveB;
        // back to track while the frame is still open
        if (edges >= CONV_EDGES) begin
            wait_lv(holdMode, 1'b0, 600, ok);
            chk({ok, frameActive}, 2'b11);
        end
        wait_lv(frameActive, 1'b0, 700, ok);
        need(ok);
        chk(powerState, pwr);
        if (edges >= CONV_EDGES) begin
            chk(holdMode, 1'b0);
        end
    endtask

    // take one response word
    task automatic take(output logic [63:0] d);
        logic ok;
        wait_lv(rspValid, 1'b1, 400, ok);
        need(ok);
        d = rspData;
        rspReady = 1'b1;
        @(posedge clock);
        #1;
        rspReady = 1'b0;
    endtask

    ////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [63:0] d;
        logic        ok;
        int          n;
        repeat (6) @(posedge clock);
        #1;
        srst = 1'b0;
        wait_lv(cmdReady, 1'b1, 30000, ok);
        need(ok);
        chk(powerState, PWR_NORMAL);
        // the power-on dummy frame buffers a word of zeros
        take(d);
        chk(d, 64'h0);
        frame(6'h10, WAKE_NONE, PWR_NORMAL);
        take(d);
        chk({d[47:32], d[15:0]}, {w16(saveA), w16(saveB)});
        frame(6'h02, WAKE_NONE, PWR_PARTIAL);
        frame(6'h01, WAKE_NONE, PWR_PARTIAL);
        frame(6'h09, WAKE_NONE, PWR_FULL);
        frame(6'h10, WAKE_FULL, PWR_NORMAL);
        take(d);
        chk({d[47:32], d[15:0]}, {w16(saveA), w16(saveB)});
        frame(6'h05, WAKE_NONE, PWR_PARTIAL);
        frame(6'h10, WAKE_PART, PWR_NORMAL);
        take(d);
        chk({d[47:32], d[15:0]}, {w16(saveA), w16(saveB)});
        frame(6'h0D, WAKE_NONE, PWR_NORMAL);
        frame(6'h0A, WAKE_NONE, PWR_NORMAL);
        frame(6'h0E, WAKE_NONE, PWR_NORMAL);
        take(d);
        chk(d, {19'h00000, saveA, 20'h00000, saveB, 1'b0});
        frame(6'h20, WAKE_NONE, PWR_NORMAL);
        take(d);
        chk(d, {w16(saveA), w16(saveB), w16(saveB), w16(saveA)});
        // fill the buffer with the reader stalled, then drain it
        n = 0;
        for (int i = 0; i < 12; i++) begin
            wait_lv(cmdReady, 1'b1, 1200, ok);
            if (ok !== 1'b1) break;
            frame(6'h10, WAKE_NONE, PWR_NORMAL);
            qa.push_back(saveA);
            qb.push_back(saveB);
            n++;
        end
        chk(n == FIFO_DEPTH || n == FIFO_DEPTH + 1, 1'b1);
        for (int i = 0; i < n; i++) begin
            take(d);
            chk({d[47:32], d[15:0]}, {w16(qa[i]), w16(qb[i])});
        end
        repeat (20) @(posedge clock);
        #1;
        chk(rspValid, 1'b0);
        final_report();
    end
endmodule // dual_adc_serial_readout_power_tb
`default_nettype wire
